/* hdl/fpw_consts.vh */
`ifndef FPW_CONSTS_VH
`define FPW_CONSTS_VH

// register byte offsets
`define FPW_ADDR_DRIVE 8'h00
`define FPW_ADDR_HALF 8'h04
`define FPW_ADDR_DIV 8'h08
`define FPW_ADDR_CTRL 8'h0c
`define FPW_ADDR_STATUS 8'h10
`define FPW_ADDR_LUT_BASE 8'h20
`define FPW_ADDR_LUT_TOP 8'h3c
`define FPW_ADDR_ID 8'h40

// reset values
`define FPW_RST_DRIVE 6'h00
`define FPW_RST_HALF 5'h17
`define FPW_RST_DIV 8'h01
`define FPW_RST_CTRL 3'h0
`define FPW_RST_LUT 6'h3f

// ctrl fields
`define FPW_CTRL_CLK_SEL 0
`define FPW_CTRL_DIV_OVR 1
`define FPW_CTRL_LUT_EN 2

// base tick dividers at 100 MHz: 360 kHz and 1.4 kHz
`define FPW_CLK_HZ 100000000
`define FPW_FAST_HZ 360000
`define FPW_SLOW_HZ 1400
`define FPW_FAST_DIV (`FPW_CLK_HZ / `FPW_FAST_HZ)
`define FPW_SLOW_DIV (`FPW_CLK_HZ / `FPW_SLOW_HZ)
`define FPW_PRE_W 17

// axi responses
`define FPW_RESP_OKAY 2'b00
`define FPW_RESP_SLVERR 2'b10

`define FPW_ID_VALUE 32'h0000_00a5

`endif

/* hdl/fpw_lut_mem.v */
`timescale 1ns/1ns
// eight-entry drive table, registered read port
module fpw_lut_mem
(
  // clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // write port
  input wire wr_en_in,
  input wire [2:0] wr_addr_in,
  input wire [5:0] wr_data_in,
  // read port
  input wire [2:0] rd_addr_in,
  output reg [5:0] rd_data_out
);
`include "fpw_consts.vh"

  reg [5:0] mem_q [0:7];
  genvar gi;

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_ent
      always @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          mem_q[gi] <= `FPW_RST_LUT;
        else if (wr_en_in && wr_addr_in == gi)
          mem_q[gi] <= wr_data_in;
      end
    end
  endgenerate

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_data_out <= `FPW_RST_LUT;
    else
      rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

/* hdl/fpw_engine.v */
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// - half-period count is ticks per half period
// - new half count changes frequency immediately
// - half count never touches stored drive levels
// - high time equals drive level ticks
// - duty is drive over twice half count
// - resolution is one tick of full period
// - drive above period gives full duty
// - frequency is base rate over twice count
// - five-bit count, zero acts as one
// - override uses divided base clock instead
// - divider ignored unless override set
// - six-bit drive, zero minimum, 3f maximum
module fpw_engine
(
  // clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // fan drive
  output reg pwm_out,
  input wire [2:0] lut_sel_in
);
`include "fpw_consts.vh"

  // registers
  reg [5:0] drive_q;
  reg [4:0] half_q;
  reg [7:0] div_q;
  reg [2:0] ctrl_q;
  reg [7:0] aw_q;
  reg aw_have_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_have_q;

  // waveform state
  reg [`FPW_PRE_W-1:0] pre_q;
  reg [7:0] dcnt_q;
  reg tick_q;
  reg [5:0] per_q;
  reg [5:0] lvl_q;
  reg lut_ok_q;
  reg [5:0] lut_lvl_q;

  wire [5:0] lut_rd;
  wire lut_we;
  wire [2:0] lut_waddr;
  wire do_write;

  function is_lut;
    input [7:0] a;
    begin
      is_lut = (a >= `FPW_ADDR_LUT_BASE) && (a <= `FPW_ADDR_LUT_TOP) && (a[1:0] == 2'b00);
    end
  endfunction

  function [5:0] eff_half;
    input [4:0] h;
    begin
      if (h == 5'h00)
        eff_half = 6'h01;
      else
        eff_half = {1'b0, h};
    end
  endfunction

  // write channel: address and data taken in either order
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  // table entries are writable only while table mode is off
  assign lut_we = do_write && is_lut(aw_q) && ws_q[0] && ctrl_q[`FPW_CTRL_LUT_EN] == 1'b0;
  assign lut_waddr = aw_q[4:2];

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPW_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      drive_q <= `FPW_RST_DRIVE;
      half_q <= `FPW_RST_HALF;
      div_q <= `FPW_RST_DIV;
      ctrl_q <= `FPW_RST_CTRL;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `FPW_RESP_OKAY;
        if (aw_q == `FPW_ADDR_DRIVE)
        begin
          // table mode owns the drive; direct writes dropped
          if (ws_q[0] && !ctrl_q[`FPW_CTRL_LUT_EN])
            drive_q <= w_q[5:0];
        end
        else if (aw_q == `FPW_ADDR_HALF)
        begin
          if (ws_q[0])
            half_q <= w_q[4:0];
        end
        else if (aw_q == `FPW_ADDR_DIV)
        begin
          if (ws_q[0])
            div_q <= w_q[7:0];
        end
        else if (aw_q == `FPW_ADDR_CTRL)
        begin
          if (ws_q[0])
            ctrl_q <= w_q[2:0];
        end
        else if (is_lut(aw_q))
          s_axi_bresp <= `FPW_RESP_OKAY;
        else if (aw_q == `FPW_ADDR_STATUS || aw_q == `FPW_ADDR_ID)
          s_axi_bresp <= `FPW_RESP_OKAY;
        else
          s_axi_bresp <= `FPW_RESP_SLVERR;
        // leaving table mode keeps the level the table last drove;
        // lut_rd may already show a bus address, so the latched level is used
        if (aw_q == `FPW_ADDR_CTRL && ws_q[0] && ctrl_q[`FPW_CTRL_LUT_EN] && !w_q[`FPW_CTRL_LUT_EN])
          drive_q <= lut_lvl_q;
      end
    end
  end

  // read channel: address held, memory read registered, answer two cycles on
  reg [7:0] ar_q;
  reg rd_pend_q;
  wire [2:0] lut_raddr;
  assign lut_raddr = rd_pend_q ? ar_q[4:2] : lut_sel_in;

  fpw_lut_mem u_lut
  (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(lut_we),
    .wr_addr_in(lut_waddr),
    .wr_data_in(w_q[5:0]),
    .rd_addr_in(lut_raddr),
    .rd_data_out(lut_rd)
  );

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FPW_RESP_OKAY;
      ar_q <= 8'h00;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !rd_pend_q && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_q <= s_axi_araddr;
        rd_pend_q <= 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_pend_q)
      begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FPW_RESP_OKAY;
        if (ar_q == `FPW_ADDR_DRIVE)
          s_axi_rdata <= {26'h0, drive_q};
        else if (ar_q == `FPW_ADDR_HALF)
          s_axi_rdata <= {27'h0, half_q};
        else if (ar_q == `FPW_ADDR_DIV)
          s_axi_rdata <= {24'h0, div_q};
        else if (ar_q == `FPW_ADDR_CTRL)
          s_axi_rdata <= {29'h0, ctrl_q};
        else if (ar_q == `FPW_ADDR_STATUS)
          s_axi_rdata <= {18'h0, pwm_out, per_q, lvl_q, 1'b0};
        else if (ar_q == `FPW_ADDR_ID)
          s_axi_rdata <= `FPW_ID_VALUE;
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FPW_RESP_SLVERR;
        end
      end
    end
  end

  // lut read data is valid for the table only when no bus read was pending the cycle before
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lut_ok_q <= 1'b0;
      lut_lvl_q <= `FPW_RST_LUT;
    end
    else
    begin
      lut_ok_q <= !rd_pend_q;
      if (lut_ok_q)
        lut_lvl_q <= lut_rd;
    end
  end
  // table entries are not readable over the bus; a pending read only borrows
  // the read port for one cycle, and the table level holds meanwhile

  // base tick: fixed prescaler or alternate divider on the fast base
  // one-clock tick; per_q and lvl_q move only on it
  // divider constants are integers; only the prescaler bits are kept
  wire [31:0] fast_lim_w;
  wire [31:0] slow_lim_w;
  wire [`FPW_PRE_W-1:0] fast_lim;
  wire [`FPW_PRE_W-1:0] pre_lim;
  assign fast_lim_w = `FPW_FAST_DIV - 1;
  assign slow_lim_w = `FPW_SLOW_DIV - 1;
  assign fast_lim = fast_lim_w[`FPW_PRE_W-1:0];
  assign pre_lim = ctrl_q[`FPW_CTRL_CLK_SEL] ? slow_lim_w[`FPW_PRE_W-1:0] : fast_lim;

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pre_q <= {`FPW_PRE_W{1'b0}};
      dcnt_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (ctrl_q[`FPW_CTRL_DIV_OVR])
      begin
        // fast base further divided by div_q, zero as one
        if (pre_q >= fast_lim)
        begin
          pre_q <= {`FPW_PRE_W{1'b0}};
          if (dcnt_q + 8'h01 >= div_q)
          begin
            dcnt_q <= 8'h00;
            tick_q <= 1'b1;
          end
          else
            dcnt_q <= dcnt_q + 8'h01;
        end
        else
          pre_q <= pre_q + 1'b1;
      end
      else if (pre_q >= pre_lim)
      begin
        pre_q <= {`FPW_PRE_W{1'b0}};
        dcnt_q <= 8'h00;
        tick_q <= 1'b1;
      end
      else
        pre_q <= pre_q + 1'b1;
    end
  end

  // period counter and compare
  wire [5:0] half_eff;
  wire [5:0] period;
  wire [5:0] level;
  wire full_duty;
  assign half_eff = eff_half(half_q);
  assign period = {half_eff[4:0], 1'b0};
  assign level = ctrl_q[`FPW_CTRL_LUT_EN] ? lut_lvl_q : drive_q;
  // level past the period end keeps the output high for the whole cycle
  assign full_duty = (lvl_q >= period);

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      per_q <= 6'h00;
      lvl_q <= `FPW_RST_DRIVE;
      pwm_out <= 1'b0;
    end
    else
    begin
      if (tick_q)
      begin
        // a shrunk period wraps on the next tick instead of running on
        if (per_q + 6'h01 >= period)
        begin
          per_q <= 6'h00;
          lvl_q <= level;
        end
        else
          per_q <= per_q + 6'h01;
      end
      pwm_out <= (lvl_q > per_q) || full_duty;
    end
  end
endmodule

/* bench/fpw_engine_assertions.sv */
`timescale 1ns/1ns
`include "fpw_consts.vh"
module fpw_chk
(
  // clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // fan drive
  input wire pwm_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("no read answer");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h44
    |-> ##[1:3] s_axi_rvalid && s_axi_rresp == `FPW_RESP_SLVERR) else $error("no slverr");
  ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  reset_idle_a: assert property ($rose(arst_n_in) |-> !s_axi_bvalid && !s_axi_rvalid && !pwm_out)
    else $error("outputs busy after reset");
  pwm_min_high_a: assert property ($rose(pwm_out) |=> pwm_out [*8])
    else $error("pwm pulse too short");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(pwm_out));
endmodule

bind fpw_engine fpw_chk u_chk (.*);

/* bench/fpw_fan_model.sv */
`timescale 1ns/1ns
// fan input stage: times each pwm cycle in core clocks
module fpw_fan_model
(
  // clock
  input wire core_clk_in,
  // pwm from the engine
  input wire pwm_in,
  // last measured cycle
  output reg [31:0] period_out = 0,
  output reg [31:0] high_out = 0
);
  reg [31:0] cnt_q = 0;
  reg last_q = 0;
  always @(posedge core_clk_in)
  begin
    last_q <= pwm_in;
    cnt_q <= cnt_q + 1;
    if (pwm_in && !last_q)
    begin
      period_out <= cnt_q + 1;
      cnt_q <= 0;
    end
    if (!pwm_in && last_q)
      high_out <= cnt_q + 1;
  end
endmodule

/* bench/test_fpw_engine.sv */
`timescale 1ns/1ns
`include "fpw_consts.vh"
module test_fpw_engine;
  localparam integer T = `FPW_FAST_DIV;
  reg core_clk_in = 0, arst_n_in = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [2:0] lut_sel_in = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, fan_period, fan_high;
  integer mismatches = 0, n_checks = 0;
  reg [31:0] d;
  reg [1:0] r;
  reg [1:0] b;
  fpw_engine dut (.*);
  fpw_fan_model fan (.core_clk_in(core_clk_in), .pwm_in(pwm_out), .period_out(fan_period), .high_out(fan_high));
  initial
  begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task axw(input [7:0] a, input [31:0] v);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
        @(posedge core_clk_in);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      b = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge core_clk_in);
    end
  endtask
  task axr(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
        @(posedge core_clk_in);
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge core_clk_in);
    end
  endtask
  // settings land first; level is only taken at a wrap, so wait three cycles
  task wave(input [4:0] h, input [5:0] lv, input [2:0] c, input [7:0] dv, input integer p, input integer hi);
    begin
      axw(`FPW_ADDR_CTRL, c);
      axw(`FPW_ADDR_DIV, dv);
      axw(`FPW_ADDR_HALF, h);
      axw(`FPW_ADDR_DRIVE, lv);
      repeat (3 * p + 50) @(posedge core_clk_in);
      chk(fan_period, p);
      chk(fan_high, hi);
    end
  endtask
  task s_reset;
    begin
      axr(`FPW_ADDR_HALF);
      chk(d, `FPW_RST_HALF);
      axr(`FPW_ADDR_DIV);
      chk(d, `FPW_RST_DIV);
      axr(`FPW_ADDR_DRIVE);
      chk(d, `FPW_RST_DRIVE);
      chk(pwm_out, 0);
      axr(8'h44);
      chk(r, `FPW_RESP_SLVERR);
      axw(8'h44, 32'h0000_0000);
      chk(b, `FPW_RESP_SLVERR);
    end
  endtask
  task s_zero;
    begin
      wave(5'h00, 6'h01, 3'h0, 8'h01, 2 * T, T);
      axw(`FPW_ADDR_HALF, 32'h0000_001f);
      chk(b, `FPW_RESP_OKAY);
      axr(`FPW_ADDR_DRIVE);
      chk(d, 1);
    end
  endtask
  task s_full;
    integer lows;
    begin
      lows = 0;
      axw(`FPW_ADDR_HALF, 1);
      axw(`FPW_ADDR_DRIVE, 6'h3f);
      repeat (4 * T) @(posedge core_clk_in);
      repeat (4 * T)
      begin
        @(posedge core_clk_in);
        if (pwm_out !== 1) lows = lows + 1;
      end
      chk(lows, 0);
    end
  endtask
  task s_ovr;
    begin
      wave(5'h01, 6'h01, 3'h2, 8'h02, 4 * T, 2 * T);
      wave(5'h01, 6'h01, 3'h0, 8'h02, 2 * T, T);
    end
  endtask
  // table level drives the output; direct drive writes are dropped meanwhile
  task s_table;
    begin
      axw(`FPW_ADDR_LUT_BASE + 8'h0c, 32'h0000_0002);
      lut_sel_in <= 3'h3;
      wave(5'h02, 6'h3f, 3'h4, 8'h01, 4 * T, 2 * T);
      axr(`FPW_ADDR_DRIVE);
      chk(d, 1);
      axw(`FPW_ADDR_CTRL, 32'h0000_0000);
      axr(`FPW_ADDR_DRIVE);
      chk(d, 2);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk_in);
    arst_n_in <= 1;
    s_reset;
    wave(5'h02, 6'h03, 3'h0, 8'h01, 4 * T, 3 * T);
    s_zero;
    s_full;
    s_ovr;
    s_table;
    end_of_test;
  end
  initial
  begin
    repeat (40000) @(posedge core_clk_in);
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule
